/* File: hw/asq_sequencer.sv */
// automatic start/stop sequencer with an apb register slave.
// assumes all pin inputs synchronous to pclk; contact_closed is 1 when the
// remote contact is closed; push buttons are level inputs, high when pressed.
`default_nettype none

module asq_sequencer #(
  parameter logic [asq_pkg::TW-1:0] TICK_CYCLES = asq_pkg::TICK_CYCLES_DEF,
  parameter logic [asq_pkg::TW-1:0] DEBOUNCE_TICKS = asq_pkg::DEBOUNCE_TICKS_DEF,
  parameter logic [asq_pkg::TW-1:0] ABSENCE_TICKS = asq_pkg::ABSENCE_TICKS_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic supply_ok,
  input wire logic panel_on_btn,
  input wire logic panel_off_btn,
  input wire logic contact_closed,
  input wire logic ext_stop_n,
  input wire logic ext_heat_n,
  input wire logic ext_crank_n,
  output logic heat_out,
  output logic crank_out,
  output logic fuel_pump_out,
  output logic panel_on
);
  import asq_pkg::*;

  // scale a phase time for test mode
  function automatic logic [TW-1:0] scale_time(input logic [TW-1:0] t, input logic test);
    scale_time = test ? (t >> TEST_SHIFT) : t;
  endfunction

  function automatic logic [TW-1:0] heat_time(input logic [7:0] sw);
    logic [1:0] sel;
    sel = {sw[SW_HEAT_HI], sw[SW_HEAT_LO]};
    unique case (sel)
      2'b00: heat_time = HEAT_2S5;
      2'b01: heat_time = HEAT_5S;
      2'b10: heat_time = HEAT_10S;
      2'b11: heat_time = HEAT_20S;
    endcase
  endfunction

  function automatic logic [TW-1:0] stop_time(input logic [7:0] sw);
    logic [1:0] sel;
    sel = {sw[SW_STOP_HI], sw[SW_STOP_LO]};
    unique case (sel)
      2'b00: stop_time = STOP_16S;
      2'b01: stop_time = STOP_32S;
      2'b10: stop_time = STOP_64S;
      2'b11: stop_time = STOP_128S;
    endcase
  endfunction

  logic [7:0] config_reg, config_next;
  logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
  logic tick;
  logic contact_db_reg, contact_db_next;
  logic [TW-1:0] db_cnt_reg, db_cnt_next;
  logic panel_reg, panel_next;
  logic [TW-1:0] absent_reg, absent_next;
  logic supply_prev_reg, supply_prev_next;
  logic level_ok_reg, level_ok_next;
  logic panel_rise;
  logic contact_rise;
  logic contact_fall;
  asq_state_t state_reg, state_next;
  logic [TW-1:0] phase_reg, phase_next;
  logic [31:0] prdata_reg, prdata_next;
  logic pslverr_reg, pslverr_next;
  logic test_mode;
  logic phase_done;
  logic [31:0] status_word;

  assign test_mode = config_reg[SW_TEST];
  assign phase_done = (phase_reg == '0);

  // free-running 1 ms tick; keeps all phase times within tolerance
  always_comb begin
    tick = 1'b0;
    tick_cnt_next = tick_cnt_reg + TW'(1);
    if (tick_cnt_reg >= TICK_CYCLES - TW'(1)) begin
      tick = 1'b1;
      tick_cnt_next = '0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= '0;
    end else if (ce) begin
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // contact debounce: a new level must hold a full second of ticks
  always_comb begin
    contact_db_next = contact_db_reg;
    db_cnt_next = db_cnt_reg;
    if (contact_closed == contact_db_reg) begin
      db_cnt_next = '0; // any bounce back restarts the wait
    end else if (tick) begin
      if (db_cnt_reg >= DEBOUNCE_TICKS - TW'(1)) begin
        contact_db_next = contact_closed;
        db_cnt_next = '0;
      end else begin
        db_cnt_next = db_cnt_reg + TW'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contact_db_reg <= 1'b0;
      db_cnt_reg <= '0;
    end else if (ce) begin
      contact_db_reg <= contact_db_next;
      db_cnt_reg <= db_cnt_next;
    end
  end

  assign contact_rise = contact_db_next & ~contact_db_reg;
  assign contact_fall = contact_db_reg & ~contact_db_next;

  // panel power state, supply watch and level-start permission
  always_comb begin
    panel_next = panel_reg;
    absent_next = absent_reg;
    supply_prev_next = supply_ok;
    level_ok_next = level_ok_reg;
    if (!supply_ok) begin
      panel_next = 1'b0; // panel drops with its supply
      if (tick && absent_reg < ABSENCE_TICKS) begin
        absent_next = absent_reg + TW'(1);
      end
    end else begin
      if (panel_off_btn) begin
        panel_next = 1'b0;
      end else if (panel_on_btn) begin
        panel_next = 1'b1;
      end
      if (!supply_prev_reg) begin
        // short drop arms level start, long absence is a fresh attach
        level_ok_next = (absent_reg < ABSENCE_TICKS);
        absent_next = '0;
      end
    end
    if (panel_reg && !panel_next) begin
      level_ok_next = level_ok_next & ~panel_off_btn; // manual off disarms
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      panel_reg <= 1'b0;
      absent_reg <= '0;
      supply_prev_reg <= 1'b1;
      level_ok_reg <= 1'b0;
    end else if (ce) begin
      panel_reg <= panel_next;
      absent_reg <= absent_next;
      supply_prev_reg <= supply_prev_next;
      level_ok_reg <= level_ok_next;
    end
  end

  assign panel_rise = panel_reg & ~panel_next ? 1'b0 : (panel_next & ~panel_reg);

  // sequencer: heat, crank, run, stop
  always_comb begin
    state_next = state_reg;
    phase_next = phase_reg;
    if (tick && !phase_done) begin
      phase_next = phase_reg - TW'(1);
    end
    if (!panel_next) begin
      state_next = ASQ_IDLE;
      phase_next = '0;
    end else begin
      unique case (state_reg)
        ASQ_IDLE: begin
          // closing edge, or panel back on after a short drop
          if (contact_db_next && (contact_rise || (panel_rise && level_ok_reg))) begin
            state_next = ASQ_HEAT;
            phase_next = scale_time(heat_time(config_reg), test_mode);
          end
        end
        ASQ_HEAT: begin
          if (contact_fall) begin
            state_next = ASQ_IDLE;
            phase_next = '0;
          end else if (phase_done) begin
            state_next = ASQ_CRANK;
            phase_next = scale_time(config_reg[SW_START] ? START_16S : START_8S,
                                    test_mode);
          end
        end
        ASQ_CRANK: begin
          if (contact_fall) begin
            state_next = ASQ_IDLE;
            phase_next = '0;
          end else if (phase_done) begin
            state_next = ASQ_RUN;
          end
        end
        ASQ_RUN: begin
          if (contact_fall) begin
            state_next = ASQ_STOP;
            phase_next = scale_time(stop_time(config_reg), test_mode);
          end
        end
        ASQ_STOP: begin
          // contact changes are ignored until the stop time is over
          if (phase_done) begin
            state_next = ASQ_IDLE;
          end
        end
        default: begin
          state_next = ASQ_IDLE;
          phase_next = '0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ASQ_IDLE;
      phase_reg <= '0;
    end else if (ce) begin
      state_reg <= state_next;
      phase_reg <= phase_next;
    end
  end

  // output drive, registered so the pins never glitch
  logic heat_reg, heat_next;
  logic crank_reg, crank_next;
  logic fuel_reg, fuel_next;

  always_comb begin
    heat_next = panel_next && ((state_next == ASQ_HEAT) || !ext_heat_n);
    crank_next = panel_next && ((state_next == ASQ_CRANK) || !ext_crank_n);
    // stop input cuts fuel in every state, even a crank in progress; heat and crank ignore it
    fuel_next = panel_next && (state_next != ASQ_STOP) && ext_stop_n;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      heat_reg <= 1'b0;
      crank_reg <= 1'b0;
      fuel_reg <= 1'b0;
    end else if (ce) begin
      heat_reg <= heat_next;
      crank_reg <= crank_next;
      fuel_reg <= fuel_next;
    end
  end

  assign heat_out = heat_reg;
  assign crank_out = crank_reg;
  assign fuel_pump_out = fuel_reg;
  assign panel_on = panel_reg;

  // status word for software
  always_comb begin
    status_word = '0;
    status_word[ST_STATE_LO +: 3] = state_reg;
    status_word[ST_PANEL] = panel_reg;
    status_word[ST_CONTACT] = contact_db_reg;
    status_word[ST_HEAT] = heat_reg;
    status_word[ST_CRANK] = crank_reg;
    status_word[ST_FUEL] = fuel_reg;
    status_word[ST_TEST] = test_mode;
    status_word[ST_SUPPLY] = supply_ok;
  end

  // apb slave: read data and error latched in setup, zero wait states
  always_comb begin
    config_next = config_reg;
    prdata_next = prdata_reg;
    pslverr_next = pslverr_reg;
    if (psel && !penable) begin
      prdata_next = '0;
      pslverr_next = 1'b0;
      unique case (paddr)
        CONFIG_OFS: prdata_next = {24'h000000, config_reg};
        STATUS_OFS: begin
          prdata_next = status_word;
          pslverr_next = pwrite; // read only
        end
        REMAIN_OFS: begin
          prdata_next = {15'h0000, phase_reg};
          pslverr_next = pwrite; // read only
        end
        default: pslverr_next = 1'b1;
      endcase
    end
    // config takes effect on the access edge; later phases pick it up
    if (psel && penable && pwrite && (paddr == CONFIG_OFS) && pstrb[0]) begin
      config_next = pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_reg <= CONFIG_RST;
      prdata_reg <= '0;
      pslverr_reg <= 1'b0;
    end else if (ce) begin
      config_reg <= config_next;
      prdata_reg <= prdata_next;
      pslverr_reg <= pslverr_next;
    end
  end

  // a frozen block holds the bus off rather than answer stale data
  assign pready = ce;
  assign prdata = prdata_reg;
  assign pslverr = pslverr_reg & psel & penable;
endmodule
`default_nettype wire

/* File: hw/asq_pkg.sv */
// constants for the automatic start/stop sequencer: register map, fields,
// reset values, state codes and phase durations.
// assumes a 100 MHz pclk and an apb master with 32-bit data.
`default_nettype none
package asq_pkg;
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned TICK_NS = 1000000; // one timer tick is 1 ms
  localparam int unsigned TICK_CYCLES_DOC = TICK_NS / CLK_PERIOD_NS;
  localparam int unsigned TW = 17; // wide enough for 128000 ms
  localparam logic [TW-1:0] TICK_CYCLES_DEF = TW'(TICK_CYCLES_DOC);
  localparam int unsigned DEBOUNCE_MS = 1000;
  localparam int unsigned ABSENCE_S = 60;
  localparam logic [TW-1:0] DEBOUNCE_TICKS_DEF = TW'(DEBOUNCE_MS);
  localparam logic [TW-1:0] ABSENCE_TICKS_DEF = TW'(ABSENCE_S * 1000);

  // phase times in ms ticks
  localparam logic [TW-1:0] HEAT_2S5 = TW'(2500);
  localparam logic [TW-1:0] HEAT_5S = TW'(5000);
  localparam logic [TW-1:0] HEAT_10S = TW'(10000);
  localparam logic [TW-1:0] HEAT_20S = TW'(20000);
  localparam logic [TW-1:0] START_8S = TW'(8000);
  localparam logic [TW-1:0] START_16S = TW'(16000);
  localparam logic [TW-1:0] STOP_16S = TW'(16000);
  localparam logic [TW-1:0] STOP_32S = TW'(32000);
  localparam logic [TW-1:0] STOP_64S = TW'(64000);
  localparam logic [TW-1:0] STOP_128S = TW'(128000);
  localparam int unsigned TEST_SHIFT = 4; // divide by 16

  // register map (byte addresses)
  localparam logic [11:0] CONFIG_OFS = 12'h000;
  localparam logic [11:0] STATUS_OFS = 12'h004;
  localparam logic [11:0] REMAIN_OFS = 12'h008;
  localparam logic [7:0] CONFIG_RST = 8'h8A; // heat 10 s, start 8 s, stop 32 s

  // switch bank field positions (bit n-1 is switch n)
  localparam int unsigned SW_HEAT_LO = 0;
  localparam int unsigned SW_HEAT_HI = 1;
  localparam int unsigned SW_START = 2;
  localparam int unsigned SW_STOP_LO = 3;
  localparam int unsigned SW_STOP_HI = 4;
  localparam int unsigned SW_TEST = 5;

  // status field positions
  localparam int unsigned ST_STATE_LO = 0;
  localparam int unsigned ST_PANEL = 3;
  localparam int unsigned ST_CONTACT = 4;
  localparam int unsigned ST_HEAT = 5;
  localparam int unsigned ST_CRANK = 6;
  localparam int unsigned ST_FUEL = 7;
  localparam int unsigned ST_TEST = 8;
  localparam int unsigned ST_SUPPLY = 9;

  typedef enum logic [2:0] {
    ASQ_IDLE = 3'b000,
    ASQ_HEAT = 3'b001,
    ASQ_CRANK = 3'b010,
    ASQ_RUN = 3'b011,
    ASQ_STOP = 3'b100
  } asq_state_t;
endpackage
`default_nettype wire

/* File: verification/asq_sequencer_checker.sv */
// pin checker for the sequencer, bound into every instance.
// assumes outputs are registered levels; checks pause while ce is low.
`default_nettype none
module asq_sequencer_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic penable,
  input wire logic pslverr,
  input wire logic supply_ok,
  input wire logic panel_on_btn,
  input wire logic panel_off_btn,
  input wire logic ext_stop_n,
  input wire logic ext_heat_n,
  input wire logic ext_crank_n,
  input wire logic heat_out,
  input wire logic crank_out,
  input wire logic fuel_pump_out,
  input wire logic panel_on
);
  default clocking @(posedge pclk); endclocking
  // a frozen block holds heat_out, crank_out, fuel_pump_out and panel_on, so timed checks are off then
  default disable iff (!presetn || !ce);
  // bus error only inside an access phase
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  // writes anywhere but the switch bank are refused
  property p_werr;
    psel && penable && pwrite && (paddr != asq_pkg::CONFIG_OFS) |-> pslverr;
  endproperty
  a_werr: assert property (p_werr) else $error("bad write accepted");
  property p_xstop; !ext_stop_n |=> !fuel_pump_out; endproperty
  a_xstop: assert property (p_xstop) else $error("fuel on during stop");
  property p_off; $fell(panel_on) |=> !heat_out && !crank_out && !fuel_pump_out; endproperty
  a_off: assert property (p_off) else $error("output after panel off");
  property p_on; $rose(panel_on) |-> $past(panel_on_btn) && $past(supply_ok); endproperty
  a_on: assert property (p_on) else $error("panel on without button");
  property p_sup; !supply_ok |=> !panel_on; endproperty
  a_sup: assert property (p_sup) else $error("panel on without supply");
  // heat and crank never overlap unless either is requested outside
  property p_excl; $past(ext_heat_n) && $past(ext_crank_n) |-> !(heat_out && crank_out);
  endproperty
  a_excl: assert property (p_excl) else $error("heat and crank together");
  property p_xheat;
    panel_on && supply_ok && !panel_off_btn && !ext_heat_n |=> heat_out;
  endproperty
  a_xheat: assert property (p_xheat) else $error("heat request lost");
  property p_xcrank;
    panel_on && supply_ok && !panel_off_btn && !ext_crank_n |=> crank_out;
  endproperty
  a_xcrank: assert property (p_xcrank) else $error("crank request lost");
endmodule
bind asq_sequencer asq_sequencer_checker u_asq_sequencer_checker (.pclk, .presetn, .ce,
  .psel, .pwrite, .paddr, .penable, .pslverr, .supply_ok, .panel_on_btn, .panel_off_btn,
  .ext_stop_n,
  .ext_heat_n, .ext_crank_n, .heat_out, .crank_out, .fuel_pump_out, .panel_on);
`default_nettype wire

/* File: verification/asq_remote_model.sv */
// panel buttons, supply, remote contact and external request pins.
// assumes tasks are called from bench processes; all pins move after pclk.
`default_nettype none
module asq_remote_model (
  input wire logic pclk,
  output logic supply_ok,
  output logic panel_on_btn,
  output logic panel_off_btn,
  output logic contact_closed,
  output logic ext_stop_n,
  output logic ext_heat_n,
  output logic ext_crank_n
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: supply present, contact open, no request
  initial begin
    {supply_ok, panel_on_btn, panel_off_btn, contact_closed} = 4'h8;
    {ext_stop_n, ext_heat_n, ext_crank_n} = 3'h7;
  end
  // potential-free contact: only open or closed, never floating
  task automatic set_contact(input logic v);
    @(posedge pclk);
    contact_closed <= v;
  endtask
  task automatic set_supply(input logic v);
    @(posedge pclk);
    supply_ok <= v;
  endtask
  task automatic set_ext(input logic [2:0] v);
    @(posedge pclk);
    {ext_stop_n, ext_heat_n, ext_crank_n} <= v;
  endtask
  // a push is a level held a few clocks, as a finger would
  task automatic push(input logic off);
    @(posedge pclk);
    panel_off_btn <= off;
    panel_on_btn <= !off;
    repeat (4) @(posedge pclk);
    {panel_on_btn, panel_off_btn} <= 2'h0;
  endtask
endmodule
`default_nettype wire

/* File: verification/asq_sequencer_tb.sv */
// bench for the sequencer: apb access and timing of every phase.
// assumes short tick parameters; test mode keeps phases to thousands of clocks.
`default_nettype none
module asq_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  import asq_pkg::*;
  localparam int TC = 10;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic ce = 1'b1;
  logic [3:0] pstrb = 4'hF;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, heat_out, crank_out, fuel_pump_out, panel_on;
  logic supply_ok, panel_on_btn, panel_off_btn, contact_closed;
  logic ext_stop_n, ext_heat_n, ext_crank_n;
  int fail_count = 0, checks = 0, cyc = 0;
  always #5 pclk = ~pclk;
  asq_sequencer #(.TICK_CYCLES(17'hA), .DEBOUNCE_TICKS(17'h4), .ABSENCE_TICKS(17'h8))
    u_asq_sequencer (.pclk, .presetn, .ce, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .supply_ok, .panel_on_btn,
    .panel_off_btn, .contact_closed, .ext_stop_n, .ext_heat_n, .ext_crank_n, .heat_out,
    .crank_out, .fuel_pump_out, .panel_on);
  asq_remote_model u_asq_remote_model (.pclk, .supply_ok, .panel_on_btn, .panel_off_btn,
    .contact_closed, .ext_stop_n, .ext_heat_n, .ext_crank_n);
  task automatic give_verdict();
    $display("TB: checks=%0d mismatches=%0d", checks, fail_count);
    if (fail_count == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // run is about 72000 clocks; a hang ends it
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fail_count++;
      give_verdict();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cmp_rng(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask
  // one transfer; request held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, wr, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends this wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    {psel, penable} <= 2'h0;
  endtask
  function automatic logic [31:0] pin(input int s);
    logic [3:0] v;
    v = {panel_on, fuel_pump_out, crank_out, heat_out};
    return {31'h0, v[s[1:0]]};
  endfunction
  // sampled on the falling edge, clear of the register updates
  task automatic hold(input int s, input logic [31:0] lvl, output int n);
    int w;
    w = 0;
    n = 0;
    while (pin(s) !== lvl && w < 30000) begin
      @(negedge pclk);
      w++;
    end
    while (pin(s) === lvl && n < 30000) begin
      @(negedge pclk);
      n++;
    end
  endtask
  task automatic pin_after(input int s, input int c, input logic [31:0] exp);
    repeat (c) @(negedge pclk);
    cmp(pin(s), exp);
  endtask
  initial begin
    logic [31:0] rd;
    logic err;
    int n;
    fork
      u_asq_remote_model.set_contact(1'b1);
    join_none
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, CONFIG_OFS, 32'h0, rd, err);
    cmp(rd, {24'h0, CONFIG_RST});
    apb(1'b0, STATUS_OFS, 32'h0, rd, err);
    cmp({28'h0, rd[3:0]}, 32'h0);
    apb(1'b1, STATUS_OFS, 32'h1, rd, err);
    cmp({31'h0, err}, 32'h1);
    apb(1'b0, 12'hFFC, 32'h0, rd, err);
    cmp({31'h0, err}, 32'h1);
    apb(1'b1, CONFIG_OFS, 32'h20, rd, err);
    // a write without its low byte strobe must not land
    pstrb <= 4'h0;
    apb(1'b1, CONFIG_OFS, 32'hFF, rd, err);
    pstrb <= 4'hF;
    apb(1'b0, CONFIG_OFS, 32'h0, rd, err);
    cmp(rd, 32'h20);
    $display("test registers done");
    repeat (100) @(posedge pclk);
    // clock enable low: the block ignores the on button and holds the bus off
    ce <= 1'b0;
    u_asq_remote_model.push(1'b0);
    cmp({31'h0, pready}, 32'h0);
    pin_after(3, 2, 32'h0);
    @(posedge pclk);
    ce <= 1'b1;
    u_asq_remote_model.push(1'b0);
    pin_after(0, 200, 32'h0);
    u_asq_remote_model.set_ext(3'h3);
    pin_after(2, 3, 32'h0);
    u_asq_remote_model.set_ext(3'h5);
    pin_after(0, 3, 32'h1);
    u_asq_remote_model.set_ext(3'h6);
    pin_after(1, 3, 32'h1);
    u_asq_remote_model.set_ext(3'h7);
    pin_after(2, 3, 32'h1);
    $display("test power attach done");
    u_asq_remote_model.set_supply(1'b0);
    repeat (30) @(posedge pclk);
    u_asq_remote_model.set_supply(1'b1);
    // push runs alongside so the heat rise is seen
    fork
      u_asq_remote_model.push(1'b0);
    join_none
    hold(0, 32'h1, n);
    cmp_rng(n, 155 * TC + 2, 156 * TC + 1);
    hold(1, 32'h1, n);
    cmp_rng(n, 499 * TC + 2, 500 * TC + 1);
    // contact recloses in mid-stop; the stop must still run out
    fork
      begin
        repeat (3000) @(posedge pclk);
        u_asq_remote_model.set_contact(1'b1);
      end
    join_none
    u_asq_remote_model.set_contact(1'b0);
    hold(2, 32'h0, n);
    cmp_rng(n, 999 * TC + 2, 1000 * TC + 1);
    u_asq_remote_model.set_contact(1'b0);
    repeat (80) @(posedge pclk);
    u_asq_remote_model.set_contact(1'b1);
    repeat (20) @(posedge pclk);
    u_asq_remote_model.set_contact(1'b0);
    pin_after(0, 100, 32'h0);
    $display("test restart and stop done");
    // heat codes 1 to 3, each aborted in crank by opening the contact
    for (int h = 1; h < 4; h++) begin
      apb(1'b1, CONFIG_OFS, 32'h20 | h, rd, err);
      u_asq_remote_model.set_contact(1'b1);
      hold(0, 32'h1, n);
      cmp_rng(n, (((2500 << h) >> 4) - 1) * TC + 2, ((2500 << h) >> 4) * TC + 1);
      u_asq_remote_model.set_contact(1'b0);
      hold(1, 32'h1, n);
      cmp_rng(n, 3 * TC, 7 * TC);
      pin_after(2, 5, 32'h1);
    end
    $display("test heat codes done");
    apb(1'b1, CONFIG_OFS, 32'h2C, rd, err);
    u_asq_remote_model.set_contact(1'b1);
    hold(0, 32'h1, n);
    hold(1, 32'h1, n);
    cmp_rng(n, 999 * TC + 2, 1000 * TC + 1);
    apb(1'b0, STATUS_OFS, 32'h0, rd, err);
    cmp({29'h0, rd[2:0]}, 32'h3);
    cmp({31'h0, rd[ST_TEST]}, 32'h1);
    u_asq_remote_model.set_contact(1'b0);
    hold(2, 32'h0, n);
    cmp_rng(n, 1999 * TC + 2, 2000 * TC + 1);
    // long supply absence with the contact closed: a fresh attach, no start
    u_asq_remote_model.set_supply(1'b0);
    u_asq_remote_model.set_contact(1'b1);
    repeat (120) @(posedge pclk);
    u_asq_remote_model.set_supply(1'b1);
    u_asq_remote_model.push(1'b0);
    pin_after(0, 200, 32'h0);
    pin_after(3, 1, 32'h1);
    u_asq_remote_model.push(1'b1);
    pin_after(3, 3, 32'h0);
    $display("test long run done");
    give_verdict();
  end
endmodule
`default_nettype wire
